// >>> core/client_loopback_addr_swap.sv
// client loopback: bad-frame drop, address swap, frame fifo and phy pipeline
// What this block does
// - Every frame that the mac flags as bad is thrown away whole and none of it is sent.
// - Frames pass from the receive side to the transmit side through a fifo; a frame that does not fit in it is dropped whole.
// - Each forwarded frame of two or more beats has its destination and source addresses exchanged.
// - With the external phy the receive side is clocked by the 156.25 MHz phy receive clock; here it runs on clk_i, shared with the transmit side.
// - The phy path is 64-bit single rate on both the mac side and the phy side.
// - On the 64-bit single-rate path the data and control lines pass through registers.
// - A lite management port, where present, is clocked between 10 and 300 MHz.
`timescale 1ns/1ps
`default_nettype none

module client_loopback_addr_swap #(
    parameter int DATA_W = loopback_pkg::DATA_W,
    parameter int KEEP_W = loopback_pkg::KEEP_W,
    parameter int CTRL_W = loopback_pkg::CTRL_W,
    parameter int FIFO_AW = loopback_pkg::FIFO_AW
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [DATA_W-1:0] rx_tdata_i,
    input wire logic [KEEP_W-1:0] rx_tkeep_i,
    input wire logic rx_tvalid_i,
    input wire logic rx_tlast_i,
    input wire logic rx_tuser_i,
    output logic [DATA_W-1:0] tx_tdata_o,
    output logic [KEEP_W-1:0] tx_tkeep_o,
    output logic tx_tvalid_o,
    output logic tx_tlast_o,
    input wire logic tx_tready_i,
    output logic frame_fwd_o,
    output logic frame_drop_o,
    input wire logic [DATA_W-1:0] mac_txd_i,
    input wire logic [CTRL_W-1:0] mac_txc_i,
    output logic [DATA_W-1:0] phy_txd_o,
    output logic [CTRL_W-1:0] phy_txc_o,
    input wire logic [DATA_W-1:0] phy_rxd_i,
    input wire logic [CTRL_W-1:0] phy_rxc_i,
    output logic [DATA_W-1:0] mac_rxd_o,
    output logic [CTRL_W-1:0] mac_rxc_o
);

    localparam int PW = FIFO_AW + 1;
    localparam int MW = DATA_W + KEEP_W + 1;
    localparam int DEPTH = 1 << FIFO_AW;
    localparam logic [PW-1:0] FULL_XOR = PW'(DEPTH);

    // frame store: {last, keep, data}
    logic [MW-1:0] mem [DEPTH];

    loopback_pkg::hold_state_e hold_reg, hold_next;
    logic [DATA_W-1:0] hdata_reg, hdata_next;
    logic [KEEP_W-1:0] hkeep_reg, hkeep_next;
    logic hlast_reg, hlast_next;
    logic hgood_reg, hgood_next;
    logic [loopback_pkg::DA_MID_W-1:0] da_mid_reg, da_mid_next;
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0] commit_reg, commit_next;
    logic ovf_reg, ovf_next;
    logic fwd_next, drop_next;
    logic wr_req, wr_en, full, commit_ok;
    logic [DATA_W-1:0] wr_data;

    logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [DATA_W-1:0] tdata_next;
    logic [KEEP_W-1:0] tkeep_next;
    logic tvalid_next, tlast_next;
    logic avail, load;
    logic [MW-1:0] rd_word;

    // write side: every beat waits in the hold stage until the next beat arrives (a last beat one cycle) so that the
    // first beat can pick up the source address that arrives in the second
    always_comb begin
        full = (wr_ptr_reg ^ rd_ptr_reg) == FULL_XOR;
        wr_req = (hold_reg != loopback_pkg::HOLD_NONE) && (rx_tvalid_i || hlast_reg);
        wr_en = wr_req && !full && !ovf_reg;
        commit_ok = wr_req && hlast_reg && hgood_reg && !full && !ovf_reg;
        // address swap on the way into the store
        case (hold_reg)
            loopback_pkg::HOLD_FIRST: begin
                if (hlast_reg) begin
                    wr_data = hdata_reg; // runt with no second beat: left as is
                end else begin
                    wr_data = {hdata_reg[loopback_pkg::W0_DA_LO_MSB:0],
                               rx_tdata_i[loopback_pkg::W1_SA_HI_MSB:0],
                               hdata_reg[DATA_W-1:loopback_pkg::W0_SA_LO_LSB]};
                end
            end
            loopback_pkg::HOLD_SECOND: begin
                wr_data = {hdata_reg[DATA_W-1:loopback_pkg::W1_KEEP_LSB], da_mid_reg};
            end
            default: begin
                wr_data = hdata_reg;
            end
        endcase
        hold_next = hold_reg;
        hdata_next = hdata_reg;
        hkeep_next = hkeep_reg;
        hlast_next = hlast_reg;
        hgood_next = hgood_reg;
        da_mid_next = da_mid_reg;
        if (rx_tvalid_i) begin
            hdata_next = rx_tdata_i;
            hkeep_next = rx_tkeep_i;
            hlast_next = rx_tlast_i;
            hgood_next = rx_tuser_i;
            case (hold_reg)
                loopback_pkg::HOLD_NONE: hold_next = loopback_pkg::HOLD_FIRST;
                loopback_pkg::HOLD_FIRST: begin
                    hold_next = hlast_reg ? loopback_pkg::HOLD_FIRST : loopback_pkg::HOLD_SECOND;
                end
                default: begin
                    hold_next = hlast_reg ? loopback_pkg::HOLD_FIRST : loopback_pkg::HOLD_BODY;
                end
            endcase
        end else if (wr_req) begin
            hold_next = loopback_pkg::HOLD_NONE; // last beat flushed, no new frame yet
        end
        if (wr_req && hold_reg == loopback_pkg::HOLD_FIRST) begin
            da_mid_next = hdata_reg[loopback_pkg::W0_DA_MID_MSB:loopback_pkg::W0_DA_MID_LSB];
        end
        // pointers: the read side only ever sees the committed pointer
        wr_ptr_next = wr_ptr_reg;
        commit_next = commit_reg;
        ovf_next = ovf_reg;
        if (wr_en) begin
            wr_ptr_next = wr_ptr_reg + PW'(1);
        end
        if (wr_req && hlast_reg) begin
            ovf_next = 1'b0;
            if (commit_ok) begin
                commit_next = wr_ptr_reg + PW'(1);
            end else begin
                wr_ptr_next = commit_reg; // rewind: bad or truncated frame vanishes
            end
        end else if (wr_req && full) begin
            ovf_next = 1'b1; // rest of this frame is discarded
        end
        fwd_next = commit_ok;
        drop_next = wr_req && hlast_reg && !commit_ok;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hold_reg <= loopback_pkg::HOLD_NONE;
            hdata_reg <= '0;
            hkeep_reg <= '0;
            hlast_reg <= 1'b0;
            hgood_reg <= 1'b0;
            da_mid_reg <= '0;
            wr_ptr_reg <= '0;
            commit_reg <= '0;
            ovf_reg <= 1'b0;
            frame_fwd_o <= 1'b0;
            frame_drop_o <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            hdata_reg <= hdata_next;
            hkeep_reg <= hkeep_next;
            hlast_reg <= hlast_next;
            hgood_reg <= hgood_next;
            da_mid_reg <= da_mid_next;
            wr_ptr_reg <= wr_ptr_next;
            commit_reg <= commit_next;
            ovf_reg <= ovf_next;
            frame_fwd_o <= fwd_next;
            frame_drop_o <= drop_next;
        end
    end

    // store has no reset; contents are only read below the committed pointer
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[wr_ptr_reg[FIFO_AW-1:0]] <= {hlast_reg, hkeep_reg, wr_data};
        end
    end

    // read side: one output register, refilled whenever it empties or is taken
    always_comb begin
        avail = commit_reg != rd_ptr_reg;
        load = avail && (!tx_tvalid_o || tx_tready_i);
        rd_word = mem[rd_ptr_reg[FIFO_AW-1:0]];
        rd_ptr_next = load ? rd_ptr_reg + PW'(1) : rd_ptr_reg;
        tvalid_next = load || (tx_tvalid_o && !tx_tready_i);
        tdata_next = load ? rd_word[DATA_W-1:0] : tx_tdata_o;
        tkeep_next = load ? rd_word[DATA_W+KEEP_W-1:DATA_W] : tx_tkeep_o;
        tlast_next = load ? rd_word[MW-1] : tx_tlast_o;
    end

    // no lite management port is built here, so no third clock domain exists
    // transmit half shares the single clock with the receive half
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_ptr_reg <= '0;
            tx_tvalid_o <= 1'b0;
            tx_tdata_o <= '0;
            tx_tkeep_o <= '0;
            tx_tlast_o <= 1'b0;
        end else begin
            rd_ptr_reg <= rd_ptr_next;
            tx_tvalid_o <= tvalid_next;
            tx_tdata_o <= tdata_next;
            tx_tkeep_o <= tkeep_next;
            tx_tlast_o <= tlast_next;
        end
    end

    // 64-bit single-rate phy path, registered once each way
    phy_pipe #(.DATA_W(DATA_W), .CTRL_W(CTRL_W)) tx_pipe (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .data_i(mac_txd_i),
        .ctrl_i(mac_txc_i),
        .data_o(phy_txd_o),
        .ctrl_o(phy_txc_o)
    );

    phy_pipe #(.DATA_W(DATA_W), .CTRL_W(CTRL_W)) rx_pipe (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .data_i(phy_rxd_i),
        .ctrl_i(phy_rxc_i),
        .data_o(mac_rxd_o),
        .ctrl_o(mac_rxc_o)
    );

    bad_no_commit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_req && hlast_reg && !hgood_reg) |=> (commit_reg == $past(commit_reg)
            && wr_ptr_reg == $past(commit_reg) && frame_drop_o))
        else $error("bad frame was committed or not rewound");

    good_commit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_req && hlast_reg && hgood_reg && !ovf_reg && !full)
            |=> (commit_reg == $past(wr_ptr_reg) + PW'(1) && frame_fwd_o))
        else $error("good frame not committed after its last beat");

    fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (PW'(wr_ptr_reg - rd_ptr_reg) <= FULL_XOR) && (PW'(commit_reg - rd_ptr_reg) <= FULL_XOR))
        else $error("fifo fill went past its depth");

    tx_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tx_tvalid_o && !tx_tready_i) |=> (tx_tvalid_o && $stable(tx_tdata_o)
            && $stable(tx_tlast_o) && $stable(tx_tkeep_o)))
        else $error("transmit beat changed while stalled");

    swap_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && hold_reg == loopback_pkg::HOLD_FIRST && !hlast_reg)
            |-> (wr_data[DATA_W-1:loopback_pkg::W0_SA_LO_LSB] == hdata_reg[15:0]
            && wr_data[loopback_pkg::W1_SA_HI_MSB:0] == {rx_tdata_i[15:0], hdata_reg[63:48]}))
        else $error("first beat addresses not swapped");

    swap_second_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_req && hold_reg == loopback_pkg::HOLD_FIRST && !hlast_reg) ##1
            (wr_en && hold_reg == loopback_pkg::HOLD_SECOND)
            |-> (wr_data[loopback_pkg::W1_SA_HI_MSB:0] == $past(hdata_reg[47:16])))
        else $error("second beat did not take the destination address");

    tx_from_commit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(rst_n_i) && $rose(tx_tvalid_o)) |-> ($past(commit_reg) != $past(rd_ptr_reg)))
        else $error("transmit started without a committed frame");

    ovf_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_req && !hlast_reg && full) |=> (ovf_reg throughout (!wr_en [*1]))
            ##0 (wr_ptr_reg == $past(wr_ptr_reg)))
        else $error("overflowing frame kept writing");

endmodule : client_loopback_addr_swap

`default_nettype wire

// >>> core/loopback_pkg.sv
// shared widths, field positions and state encodings for the client loopback
package loopback_pkg;

    // client stream and phy path widths
    localparam int DATA_W = 64;
    localparam int KEEP_W = 8;
    localparam int CTRL_W = 8;
    localparam int FIFO_AW = 9;

    // address field positions inside the first two 64-bit beats of a frame
    localparam int W0_DA_LO_MSB = 15;
    localparam int W0_DA_MID_LSB = 16;
    localparam int W0_DA_MID_MSB = 47;
    localparam int W0_SA_LO_LSB = 48;
    localparam int W1_SA_HI_MSB = 31;
    localparam int W1_KEEP_LSB = 32;
    localparam int DA_MID_W = 32;

    // reset values of the phy pipeline stages
    localparam logic [DATA_W-1:0] PIPE_RST_DATA = 64'h0000_0000_0000_0000;
    localparam logic [CTRL_W-1:0] PIPE_RST_CTRL = 8'h00;

    // which beat of the current frame the hold stage carries (gray along the path)
    typedef enum logic [1:0] {
        HOLD_NONE   = 2'b00,
        HOLD_FIRST  = 2'b01,
        HOLD_SECOND = 2'b11,
        HOLD_BODY   = 2'b10
    } hold_state_e;

endpackage : loopback_pkg

// >>> core/phy_pipe.sv
// one registered stage on a data and control path between mac and phy
`timescale 1ns/1ps
`default_nettype none

module phy_pipe #(
    parameter int DATA_W = loopback_pkg::DATA_W,
    parameter int CTRL_W = loopback_pkg::CTRL_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [CTRL_W-1:0] ctrl_i,
    output logic [DATA_W-1:0] data_o,
    output logic [CTRL_W-1:0] ctrl_o
);

    logic [DATA_W-1:0] data_next;
    logic [CTRL_W-1:0] ctrl_next;

    // plain pass-through; the stage exists only to ease timing at the boundary
    always_comb begin
        data_next = data_i;
        ctrl_next = ctrl_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_o <= DATA_W'(loopback_pkg::PIPE_RST_DATA);
            ctrl_o <= CTRL_W'(loopback_pkg::PIPE_RST_CTRL);
        end else begin
            data_o <= data_next;
            ctrl_o <= ctrl_next;
        end
    end

    // two beats in a row come out in the same order, one cycle late
    pipe_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> ##1 (data_o == $past(data_i) && ctrl_o == $past(ctrl_i)))
        else $error("phy pipeline stage lost or reordered a beat");

endmodule : phy_pipe

`default_nettype wire

// >>> tb/client_loopback_addr_swap_bench.sv
// self-checking bench for the client loopback with address swap
`timescale 1ns/1ps
`default_nettype none

module client_loopback_addr_swap_bench;
    localparam int AW = 4; // small fifo so that overflow is reachable
    logic clk_i, rst_n_i, rx_tvalid, rx_tlast, rx_tuser, tx_tvalid, tx_tlast, tx_tready;
    logic frame_fwd, frame_drop, stall, slow;
    logic [63:0] rx_tdata, tx_tdata, mac_txd, phy_txd, phy_rxd, mac_rxd;
    logic [7:0] rx_tkeep, tx_tkeep, mac_txc, phy_txc, phy_rxc, mac_rxc;
    logic [63:0] exp_d[$];
    logic [7:0] exp_k[$];
    logic exp_l[$];
    int mismatches;
    int checks_done;

    client_loopback_addr_swap #(.FIFO_AW(AW)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .rx_tdata_i(rx_tdata), .rx_tkeep_i(rx_tkeep), .rx_tvalid_i(rx_tvalid),
        .rx_tlast_i(rx_tlast), .rx_tuser_i(rx_tuser), .tx_tdata_o(tx_tdata),
        .tx_tkeep_o(tx_tkeep), .tx_tvalid_o(tx_tvalid), .tx_tlast_o(tx_tlast),
        .tx_tready_i(tx_tready), .frame_fwd_o(frame_fwd), .frame_drop_o(frame_drop),
        .mac_txd_i(mac_txd), .mac_txc_i(mac_txc), .phy_txd_o(phy_txd), .phy_txc_o(phy_txc),
        .phy_rxd_i(phy_rxd), .phy_rxc_i(phy_rxc), .mac_rxd_o(mac_rxd), .mac_rxc_o(mac_rxc));

    mac_client_model i_mac (.clk_i(clk_i), .stall_i(stall), .slow_i(slow),
        .tx_tdata_i(tx_tdata), .tx_tkeep_i(tx_tkeep), .tx_tvalid_i(tx_tvalid),
        .tx_tlast_i(tx_tlast), .tx_tready_o(tx_tready));

    // free-running clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // beat pattern with distinct bytes, so a misplaced byte shows
    function automatic logic [63:0] pat(input int s, input int i);
        return 64'h1d2c_3b4a_5968_7786 * 64'(s * 8 + i + 1);
    endfunction : pat

    // expected output: beat0/beat1 addresses exchanged, one-beat frames untouched
    task automatic expect_frame(input int s, input int n);
        logic [63:0] b0, b1, d;
        b0 = pat(s, 0);
        b1 = pat(s, 1);
        for (int i = 0; i < n; i++) begin
            d = pat(s, i);
            if (n > 1 && i == 0) d = {b0[15:0], b1[31:0], b0[63:48]};
            if (n > 1 && i == 1) d = {b1[63:32], b0[47:16]};
            exp_d.push_back(d);
            exp_k.push_back((i == n - 1) ? 8'h0f : 8'hff);
            exp_l.push_back(i == n - 1);
        end
    endtask : expect_frame

    // drives one frame and judges the forward/drop pulse two edges after its last beat
    task automatic send(input int s, input int n, input logic good, input logic fwd);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            rx_tdata = pat(s, i);
            rx_tkeep = (i == n - 1) ? 8'h0f : 8'hff;
            rx_tvalid = 1'b1;
            rx_tlast = (i == n - 1);
            rx_tuser = (i == n - 1) ? good : ~good;
        end
        @(negedge clk_i);
        rx_tvalid = 1'b0;
        rx_tlast = 1'b0;
        rx_tdata = ~rx_tdata; // idle data is inverted once, so it never parks on the last beat
        // the pulse stands between the second and third edge after the last beat
        @(negedge clk_i);
        check(64'({frame_fwd, frame_drop}), 64'({fwd, ~fwd}));
    endtask : send

    // waits for the expected beats under a bound, then compares them in order
    task automatic drain();
        int k;
        k = 0;
        while (i_mac.got_d.size() < exp_d.size() && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        repeat (20) @(posedge clk_i);
        if (i_mac.got_d.size() < exp_d.size()) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, i_mac.got_d.size(), exp_d.size());
            wrap_up();
        end
        check(64'(i_mac.got_d.size()), 64'(exp_d.size()));
        for (int i = 0; i < exp_d.size() && i < i_mac.got_d.size(); i++) begin
            check(i_mac.got_d[i], exp_d[i]);
            check(64'({i_mac.got_k[i], 7'h00, i_mac.got_l[i]}),
                64'({exp_k[i], 7'h00, exp_l[i]}));
        end
        i_mac.got_d.delete();
        i_mac.got_k.delete();
        i_mac.got_l.delete();
        exp_d.delete();
        exp_k.delete();
        exp_l.delete();
    endtask : drain

    // phy paths: output follows input exactly one edge later
    task automatic t_pipe();
        logic [63:0] a;
        a = 64'ha5c3_0f1e_3c96_7b12;
        @(negedge clk_i);
        mac_txd = a;
        mac_txc = 8'h5a;
        phy_rxd = ~a;
        phy_rxc = 8'hc3;
        @(negedge clk_i);
        mac_txd = 64'h0;
        phy_rxd = 64'h0;
        check(phy_txd, a);
        check(mac_rxd, ~a);
        check(64'({phy_txc, mac_rxc}), 64'h5ac3);
    endtask : t_pipe

    // swapped multi-beat frame, then an unswapped one-beat frame
    task automatic t_swap();
        expect_frame(1, 3);
        send(1, 3, 1'b1, 1'b1);
        expect_frame(2, 1);
        send(2, 1, 1'b1, 1'b1);
        drain();
    endtask : t_swap

    // bad frame vanishes whole; the good one after it still passes
    task automatic t_bad();
        send(3, 4, 1'b0, 1'b0);
        expect_frame(4, 2);
        send(4, 2, 1'b1, 1'b1);
        drain();
    endtask : t_bad

    // stalled transmitter: the output register holds one beat, so 14 stay in the store;
    // a 4-beat frame then overflows mid-frame and a 3-beat one finds it full at its end
    task automatic t_fill();
        @(negedge clk_i);
        stall = 1'b1;
        repeat (2) @(negedge clk_i);
        for (int f = 0; f < 5; f++) begin
            expect_frame(10 + f, 3);
            send(10 + f, 3, 1'b1, 1'b1);
        end
        send(20, 4, 1'b1, 1'b0);
        send(21, 3, 1'b1, 1'b0);
        @(negedge clk_i);
        stall = 1'b0;
        slow = 1'b1;
        drain();
        slow = 1'b0;
    endtask : t_fill

    // main sequence
    initial begin
        mismatches = 0;
        checks_done = 0;
        rst_n_i = 1'b0;
        {rx_tvalid, rx_tlast, rx_tuser, stall, slow} = 5'h00;
        rx_tdata = 64'h0;
        rx_tkeep = 8'h00;
        {mac_txd, phy_rxd, mac_txc, phy_rxc} = '0;
        repeat (12) @(negedge clk_i);
        check(64'({tx_tvalid, frame_fwd, frame_drop}), 64'h0);
        rst_n_i = 1'b1;
        t_pipe();
        t_swap();
        t_bad();
        t_fill();
        wrap_up();
    end
endmodule : client_loopback_addr_swap_bench

`default_nettype wire

// >>> tb/mac_client_model.sv
// mac-side client model: paces transmit ready and records every beat taken
`timescale 1ns/1ps
`default_nettype none

module mac_client_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire logic [loopback_pkg::DATA_W-1:0] tx_tdata_i,
    input wire logic [loopback_pkg::KEEP_W-1:0] tx_tkeep_i,
    input wire logic tx_tvalid_i,
    input wire logic tx_tlast_i,
    output logic tx_tready_o
);
    logic [loopback_pkg::DATA_W-1:0] got_d[$];
    logic [loopback_pkg::KEEP_W-1:0] got_k[$];
    logic got_l[$];
    logic phase;

    initial begin
        tx_tready_o = 1'b0;
        phase = 1'b0;
    end

    // ready moves on the falling edge only; slow mode takes every other beat
    always @(negedge clk_i) begin
        phase <= ~phase;
        tx_tready_o <= ~stall_i & (~slow_i | phase);
    end

    // a beat is taken at the transmit clock edge where valid meets ready
    always @(posedge clk_i) begin
        if (tx_tvalid_i === 1'b1 && tx_tready_o === 1'b1) begin
            got_d.push_back(tx_tdata_i);
            got_k.push_back(tx_tkeep_i);
            got_l.push_back(tx_tlast_i);
        end
    end
endmodule : mac_client_model

`default_nettype wire
